// *** bvr_regs.sv ***
// Buck converter set point and configuration register bank
// How it works
// - Code gives 300 mV plus 25 mV steps
// - Three codes; apply the current state's code
// - Normal code at 0x20, bits 5:0, reset zero
// - Standby code at 0x21, bits 5:0, reset zero
// - Sleep code at 0x22, bits 5:0, reset zero
// - Mode field at 0x23 bits 3:0
// - Mode bit 5: sleep off or pulse-frequency
// - Config bit 0 picks high or low limit
// - Config bits 3:2 pick switching frequency
// - Config bits 5:4 pick clock phase
// - Config bits 7:6 pick ramp speed
// - Frequency 1, 2, 4 MHz; 11 reserved
// - Phase 0, 90, 180, 270 degrees
// - One config shared by both switching nodes
`timescale 1ns/1ps
`default_nettype none
module bvr_regs #(
    parameter logic [3:0] SLEEP_PFM_MODE = 4'h1,
    parameter int RAMP_CYC0 = bvr_pkg::RAMP_CYC0,
    parameter int RAMP_CYC1 = bvr_pkg::RAMP_CYC1,
    parameter int RAMP_CYC2 = bvr_pkg::RAMP_CYC2,
    parameter int RAMP_CYC3 = bvr_pkg::RAMP_CYC3
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata_q,
    output logic reg_rvalid_q,
    input wire bvr_pkg::bvr_pwr_e pwr_state,
    output logic [5:0] applied_code_q,
    output logic [10:0] vout_mv_q,
    output logic ramp_busy_q,
    output logic conv_en_q,
    output logic [3:0] switching_mode_select_q,
    output logic current_limit_level_q,
    output logic [1:0] switching_frequency_select_q,
    output logic [12:0] freq_khz_q,
    output logic [1:0] clock_phase_select_q,
    output logic [8:0] clock_phase_deg_q,
    output logic [1:0] voltage_ramp_speed_q
);
    import bvr_pkg::*;

    logic [5:0] normal_voltage_code_q;
    logic [5:0] standby_voltage_code_q;
    logic [5:0] sleep_voltage_code_q;
    logic [3:0] mode_field_q;
    logic sleep_state_select_q;
    logic [7:0] conf_q;
    logic [5:0] target_d;
    logic [7:0] rdata_d;
    logic wr_go;

    bvr_ramp_if rif ();

    ////////////////////////////////////////////////////////////////////////////////
    // Register writes

    assign wr_go = clk_en && reg_wr;

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            normal_voltage_code_q <= CODE_RST;
            standby_voltage_code_q <= CODE_RST;
            sleep_voltage_code_q <= CODE_RST;
        end
        else if (wr_go)
        begin
            if (reg_addr == ADDR_NORMAL)
                normal_voltage_code_q <= reg_wdata[CODE_LSB +: 6];
            if (reg_addr == ADDR_STANDBY)
                standby_voltage_code_q <= reg_wdata[CODE_LSB +: 6];
            if (reg_addr == ADDR_SLEEP)
                sleep_voltage_code_q <= reg_wdata[CODE_LSB +: 6];
        end
    end

    // The documented 0x80 default lies outside the 4-bit field; only its low bits are kept
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            mode_field_q <= MODE_RST[MODE_LSB +: 4];
            sleep_state_select_q <= 1'b0;
        end
        else if (wr_go && reg_addr == ADDR_MODE)
        begin
            mode_field_q <= reg_wdata[MODE_LSB +: 4];
            sleep_state_select_q <= reg_wdata[OMODE_BIT];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            conf_q <= CONF_RST;
        else if (wr_go && reg_addr == ADDR_CONF)
            conf_q <= reg_wdata;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register reads; unused bits and unmapped addresses read zero

    always_comb
    begin
        case (reg_addr)
            ADDR_NORMAL: rdata_d = {2'b00, normal_voltage_code_q};
            ADDR_STANDBY: rdata_d = {2'b00, standby_voltage_code_q};
            ADDR_SLEEP: rdata_d = {2'b00, sleep_voltage_code_q};
            ADDR_MODE: rdata_d = {2'b00, sleep_state_select_q, 1'b0, mode_field_q};
            ADDR_CONF: rdata_d = conf_q;
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            reg_rdata_q <= 8'h00;
            reg_rvalid_q <= 1'b0;
        end
        else if (clk_en)
        begin
            reg_rvalid_q <= reg_rd;
            if (reg_rd)
                reg_rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Power state selection and ramp

    always_comb
    begin
        case (pwr_state)
            PWR_STANDBY: target_d = standby_voltage_code_q;
            PWR_SLEEP: target_d = sleep_voltage_code_q;
            default: target_d = normal_voltage_code_q;
        endcase
    end

    // The host keeps codes above 0.6 V; the bank stores whatever it is given
    assign rif.target = target_d;
    assign rif.speed = conf_q[SPEED_LSB +: 2];

    bvr_ramp #(
        .CYC0(RAMP_CYC0),
        .CYC1(RAMP_CYC1),
        .CYC2(RAMP_CYC2),
        .CYC3(RAMP_CYC3)
    ) u_ramp (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .rif(rif)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Converter outputs, one setting shared by both switching nodes

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            applied_code_q <= CODE_RST;
            vout_mv_q <= 11'(VOUT_BASE_MV);
            ramp_busy_q <= 1'b0;
        end
        else if (clk_en)
        begin
            applied_code_q <= rif.code;
            vout_mv_q <= 11'(VOUT_BASE_MV + VOUT_STEP_MV * int'(rif.code));
            ramp_busy_q <= rif.busy;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            conv_en_q <= 1'b1;
            switching_mode_select_q <= MODE_RST[MODE_LSB +: 4];
        end
        else if (clk_en)
        begin
            conv_en_q <= !(pwr_state == PWR_SLEEP && !sleep_state_select_q);
            if (pwr_state == PWR_SLEEP && sleep_state_select_q)
                switching_mode_select_q <= SLEEP_PFM_MODE;
            else
                switching_mode_select_q <= mode_field_q;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            current_limit_level_q <= CONF_RST[ILIM_BIT];
            switching_frequency_select_q <= CONF_RST[FREQ_LSB +: 2];
            clock_phase_select_q <= CONF_RST[PHASE_LSB +: 2];
            voltage_ramp_speed_q <= CONF_RST[SPEED_LSB +: 2];
            freq_khz_q <= 13'(FREQ0_KHZ);
            clock_phase_deg_q <= 9'h000;
        end
        else if (clk_en)
        begin
            current_limit_level_q <= conf_q[ILIM_BIT];
            switching_frequency_select_q <= conf_q[FREQ_LSB +: 2];
            clock_phase_select_q <= conf_q[PHASE_LSB +: 2];
            voltage_ramp_speed_q <= conf_q[SPEED_LSB +: 2];
            clock_phase_deg_q <= 9'(PHASE_STEP_DEG * int'(conf_q[PHASE_LSB +: 2]));
            case (conf_q[FREQ_LSB +: 2])
                2'b00: freq_khz_q <= 13'(FREQ0_KHZ);
                2'b01: freq_khz_q <= 13'(FREQ1_KHZ);
                2'b10: freq_khz_q <= 13'(FREQ2_KHZ);
                default: freq_khz_q <= 13'h0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    a_vout_decode: assert property (clk_en |=>
        vout_mv_q == 11'(VOUT_BASE_MV + VOUT_STEP_MV * int'(applied_code_q)))
        else $error("output millivolts disagree with applied code");

    a_state_target: assert property (pwr_state == PWR_STANDBY |->
        rif.target == standby_voltage_code_q)
        else $error("standby state does not target standby code");

    a_normal_write: assert property (wr_go && reg_addr == ADDR_NORMAL |=>
        normal_voltage_code_q == $past(reg_wdata[5:0]))
        else $error("normal code write lost");

    a_standby_write: assert property (wr_go && reg_addr == ADDR_STANDBY |=>
        standby_voltage_code_q == $past(reg_wdata[5:0]))
        else $error("standby code write lost");

    a_sleep_read: assert property (clk_en && reg_rd && reg_addr == ADDR_SLEEP |=>
        reg_rvalid_q && reg_rdata_q == $past({2'b00, sleep_voltage_code_q}))
        else $error("sleep code read wrong");

    a_mode_read: assert property (clk_en && reg_rd && reg_addr == ADDR_MODE |=>
        reg_rdata_q[7:6] == 2'b00 && reg_rdata_q[4] == 1'b0
        && reg_rdata_q[3:0] == $past(mode_field_q))
        else $error("mode register read wrong");

    a_sleep_off: assert property (clk_en && pwr_state == PWR_SLEEP && !sleep_state_select_q
        |=> !conv_en_q)
        else $error("converter not off in sleep");

    a_ilim_follow: assert property (wr_go && reg_addr == ADDR_CONF && clk_en ##1 clk_en |=>
        current_limit_level_q == $past(reg_wdata[0], 2))
        else $error("current limit does not follow config");

    a_freq_decode: assert property (clk_en && conf_q[3:2] == 2'b10 |=>
        freq_khz_q == 13'(FREQ2_KHZ))
        else $error("frequency decode wrong");

    a_phase_decode: assert property (clk_en && conf_q[5:4] == 2'b11 |=>
        clock_phase_deg_q == 9'd270 && clock_phase_select_q == 2'b11)
        else $error("phase decode wrong");
endmodule : bvr_regs
`default_nettype wire

// *** bvr_pkg.sv ***
// Constants and types shared by the buck set point register bank
`default_nettype none
package bvr_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam logic [7:0] ADDR_NORMAL = 8'h20;
    localparam logic [7:0] ADDR_STANDBY = 8'h21;
    localparam logic [7:0] ADDR_SLEEP = 8'h22;
    localparam logic [7:0] ADDR_MODE = 8'h23;
    localparam logic [7:0] ADDR_CONF = 8'h24;
    localparam logic [5:0] CODE_RST = 6'h00;
    localparam logic [7:0] MODE_RST = 8'h80;
    localparam logic [7:0] CONF_RST = 8'h00;
    localparam int CODE_LSB = 0;
    localparam int MODE_LSB = 0;
    localparam int OMODE_BIT = 5;
    localparam int ILIM_BIT = 0;
    localparam int FREQ_LSB = 2;
    localparam int PHASE_LSB = 4;
    localparam int SPEED_LSB = 6;
    localparam int VOUT_BASE_MV = 300;
    localparam int VOUT_STEP_MV = 25;
    localparam int FREQ0_KHZ = 1000;
    localparam int FREQ1_KHZ = 2000;
    localparam int FREQ2_KHZ = 4000;
    localparam int PHASE_STEP_DEG = 90;
    localparam int RAMP_T0_NS = 2000;
    localparam int RAMP_T1_NS = 4000;
    localparam int RAMP_T2_NS = 8000;
    localparam int RAMP_T3_NS = 16000;
    localparam int RAMP_CYC0 = (RAMP_T0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RAMP_CYC1 = (RAMP_T1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RAMP_CYC2 = (RAMP_T2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RAMP_CYC3 = (RAMP_T3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RAMP_CNT_W = 11;

    typedef enum logic [1:0] {
        PWR_NORMAL = 2'b00,
        PWR_STANDBY = 2'b01,
        PWR_SLEEP = 2'b10
    } bvr_pwr_e;
endpackage : bvr_pkg
`default_nettype wire

// *** bvr_ramp_if.sv ***
// Carrier between the register bank and the voltage ramp stepper
`timescale 1ns/1ps
`default_nettype none
interface bvr_ramp_if;
    logic [5:0] target;
    logic [1:0] speed;
    logic [5:0] code;
    logic busy;
    modport ctrl (output target, output speed, input code, input busy);
    modport stepper (input target, input speed, output code, output busy);
endinterface : bvr_ramp_if
`default_nettype wire

// *** bvr_ramp.sv ***
// Voltage code ramp stepper: one code step per selected interval
`timescale 1ns/1ps
`default_nettype none
module bvr_ramp #(
    parameter int CYC0 = bvr_pkg::RAMP_CYC0,
    parameter int CYC1 = bvr_pkg::RAMP_CYC1,
    parameter int CYC2 = bvr_pkg::RAMP_CYC2,
    parameter int CYC3 = bvr_pkg::RAMP_CYC3
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    bvr_ramp_if.stepper rif
);
    import bvr_pkg::*;

    logic [RAMP_CNT_W-1:0] cnt_q;
    logic [RAMP_CNT_W-1:0] lim;
    logic [5:0] code_q;

    always_comb
    begin
        case (rif.speed)
            2'b00: lim = RAMP_CNT_W'(CYC0 - 1);
            2'b01: lim = RAMP_CNT_W'(CYC1 - 1);
            2'b10: lim = RAMP_CNT_W'(CYC2 - 1);
            default: lim = RAMP_CNT_W'(CYC3 - 1);
        endcase
    end

    // Compare with >= so a speed change mid-interval never strands the counter
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            cnt_q <= '0;
            code_q <= CODE_RST;
        end
        else if (clk_en)
        begin
            if (code_q == rif.target)
                cnt_q <= '0;
            else if (cnt_q >= lim)
            begin
                cnt_q <= '0;
                code_q <= (code_q < rif.target) ? code_q + 6'h01 : code_q - 6'h01;
            end
            else
                cnt_q <= cnt_q + RAMP_CNT_W'(1);
        end
    end

    assign rif.code = code_q;
    assign rif.busy = (code_q != rif.target);

    a_ramp_one_code: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en |=> (code_q == $past(code_q)) || (code_q == $past(code_q) + 6'h01)
            || (code_q == $past(code_q) - 6'h01))
        else $error("ramp moved more than one code");

    a_ramp_step_up: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && code_q < rif.target && cnt_q >= lim |=> code_q == $past(code_q) + 6'h01)
        else $error("ramp did not step up at interval end");

    a_ramp_holds_early: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && cnt_q < lim |=> code_q == $past(code_q))
        else $error("ramp stepped before its interval ended");
endmodule : bvr_ramp
`default_nettype wire

// *** bvr_host.sv ***
// Host model that programs the set point registers over the strobe port
`timescale 1ns/1ps
`default_nettype none
module bvr_host (
    input wire logic core_clk,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata_q,
    input wire logic reg_rvalid_q
);
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Released lines show the inverse so a stale value never passes for a fresh one
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a inside {8'h20, 8'h21, 8'h22} && v[5:0] <= 6'h0c)
            v[5:0] = 6'h0d;
        @(posedge core_clk);
        #1;
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(posedge core_clk);
        #1;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~v;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge core_clk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge core_clk);
        #1;
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata_q;
        v = reg_rvalid_q;
    endtask : rd
endmodule : bvr_host
`default_nettype wire

// *** bvr_regs_test.sv ***
// Self-checking bench for the buck set point register bank
`timescale 1ns/1ps
`default_nettype none
module bvr_regs_test;
    import bvr_pkg::*;
    localparam logic [3:0] PFM_CODE = 4'h1;
    localparam int GAP0 = 3;
    localparam int GAP1 = 4;
    localparam int GAP2 = 5;
    localparam int GAP3 = 6;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    bvr_pwr_e pwr_state = PWR_NORMAL;
    logic [7:0] reg_addr, reg_wdata, reg_rdata_q;
    logic reg_wr, reg_rd, reg_rvalid_q, ramp_busy_q, conv_en_q, current_limit_level_q;
    logic [5:0] applied_code_q;
    logic [10:0] vout_mv_q;
    logic [3:0] switching_mode_select_q;
    logic [1:0] switching_frequency_select_q, clock_phase_select_q, voltage_ramp_speed_q;
    logic [12:0] freq_khz_q;
    logic [8:0] clock_phase_deg_q;
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;

    always #5 core_clk = ~core_clk;

    bvr_host host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .reg_rvalid_q(reg_rvalid_q));

    // Short ramp intervals keep the run brief; expectations also check the interval between steps
    bvr_regs #(.SLEEP_PFM_MODE(PFM_CODE), .RAMP_CYC0(GAP0), .RAMP_CYC1(GAP1),
        .RAMP_CYC2(GAP2), .RAMP_CYC3(GAP3)) dut (.core_clk(core_clk), .sys_rst(sys_rst),
        .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q), .pwr_state(pwr_state),
        .applied_code_q(applied_code_q), .vout_mv_q(vout_mv_q),
        .ramp_busy_q(ramp_busy_q), .conv_en_q(conv_en_q),
        .switching_mode_select_q(switching_mode_select_q),
        .current_limit_level_q(current_limit_level_q),
        .switching_frequency_select_q(switching_frequency_select_q),
        .freq_khz_q(freq_khz_q), .clock_phase_select_q(clock_phase_select_q),
        .clock_phase_deg_q(clock_phase_deg_q), .voltage_ramp_speed_q(voltage_ramp_speed_q));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            print_verdict();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : check

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        host.rd(a, d, v);
        check({15'h0, v}, 16'h0001);
        check({8'h00, d}, {8'h00, exp});
    endtask : rd_chk

    // Waits for the applied code to settle, watching that it never jumps and that
    // every step after the first lands exactly one interval after the one before
    task automatic wait_ramp(input logic [5:0] exp, input int gap_exp);
        logic [5:0] prev;
        int gap;
        int steps;
        prev = applied_code_q;
        gap = 0;
        steps = 0;
        for (int i = 0; i < 600 && applied_code_q !== exp; i++)
        begin
            @(posedge core_clk);
            #1;
            gap++;
            if (applied_code_q !== exp)
                check(ramp_busy_q, 1'b1);
            if (applied_code_q !== prev && applied_code_q !== prev + 6'd1
                && applied_code_q !== prev - 6'd1)
                check(applied_code_q, prev);
            if (applied_code_q !== prev)
            begin
                if (steps > 0)
                    check(16'(gap), 16'(gap_exp));
                gap = 0;
                steps++;
            end
            prev = applied_code_q;
        end
        repeat (3) @(posedge core_clk);
        #1;
        check(applied_code_q, exp);
        check(ramp_busy_q, 1'b0);
        check(vout_mv_q, 11'd300 + 11'd25 * exp);
    endtask : wait_ramp

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        for (int a = 8'h20; a <= 8'h24; a++)
            rd_chk(a[7:0], 8'h00);
        rd_chk(8'h30, 8'h00);
        check(vout_mv_q, 11'd300);
        check(conv_en_q, 1'b1);
        check(freq_khz_q, 13'd1000);
        check(clock_phase_deg_q, 9'd0);
        $display("t_reset done");
    endtask : t_reset

    task automatic t_fields();
        logic [7:0] exp [5] = '{8'h3f, 8'h3f, 8'h3f, 8'h2f, 8'hff};
        for (int a = 0; a < 5; a++)
            host.wr(8'h20 + a[7:0], 8'hff);
        for (int a = 0; a < 5; a++)
            rd_chk(8'h20 + a[7:0], exp[a]);
        host.wr(8'h30, 8'h00);
        check(current_limit_level_q, 1'b1);
        check(switching_frequency_select_q, 2'b11);
        check(freq_khz_q, 13'd0);
        check(clock_phase_select_q, 2'b11);
        check(clock_phase_deg_q, 9'd270);
        check(voltage_ramp_speed_q, 2'b11);
        clk_en = 1'b0;
        host.wr(8'h24, 8'h00);
        clk_en = 1'b1;
        rd_chk(8'h24, 8'hff);
        $display("t_fields done");
    endtask : t_fields

    task automatic t_table();
        for (int i = 0; i < 4; i++)
        begin
            host.wr(8'h24, {2'b00, i[1:0], i[1:0], 2'b01});
            repeat (3) @(posedge core_clk);
            #1;
            check(freq_khz_q, (i == 3) ? 13'd0 : 13'd1000 << i);
            check(clock_phase_deg_q, 9'd90 * i[8:0]);
            check(current_limit_level_q, 1'b1);
            check(voltage_ramp_speed_q, 2'b00);
        end
        $display("t_table done");
    endtask : t_table

    task automatic t_ramp();
        host.wr(8'h20, 8'h10);
        host.wr(8'h21, 8'h14);
        host.wr(8'h22, 8'h0e);
        host.wr(8'h23, 8'h03);
        wait_ramp(6'h10, GAP0);
        check(switching_mode_select_q, 4'h3);
        host.wr(8'h24, 8'h40);
        pwr_state = PWR_STANDBY;
        wait_ramp(6'h14, GAP1);
        pwr_state = PWR_SLEEP;
        wait_ramp(6'h0e, GAP1);
        check(conv_en_q, 1'b0);
        host.wr(8'h23, 8'h23);
        repeat (3) @(posedge core_clk);
        #1;
        check(conv_en_q, 1'b1);
        check(switching_mode_select_q, PFM_CODE);
        host.wr(8'h24, 8'hc0);
        pwr_state = PWR_NORMAL;
        wait_ramp(6'h10, GAP3);
        $display("t_ramp done");
    endtask : t_ramp

    initial
    begin
        repeat (5) @(posedge core_clk);
        #1;
        sys_rst = 1'b0;
        t_reset();
        t_fields();
        t_table();
        t_ramp();
        print_verdict();
    end
endmodule : bvr_regs_test
`default_nettype wire
